// ### verilog/sps_port.sv
`timescale 1ns/10ps
`include "sps_regs.svh"
module sps_port
  import sps_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       page_sel,
  input  wire logic       instr_tick,
  input  wire logic       slow_tick,
  input  wire logic       clk_src_slow,
  input  wire logic       irq_clear,
  output logic            read_buffer_full_irq,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe
);
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [7:0]  ctrl;
    logic [7:0]  write_buffer;
    logic [7:0]  shift_register;
    logic [2:0]  bitcnt;
    logic        busy;
    logic [4:0]  div;
    logic        sck;
    logic        sck_prev;
    logic        sdo;
    logic        irq;
    logic [7:0]  rdata;
    logic [7:0]  rx_sr;
    logic [1:0]  cap;
    logic [1:0]  fin;
    sps_phase_t  phase;
  } sps_st_t;
  sps_st_t s_r, s_nxt;
  logic       rst_n;
  logic [2:0] pins_q;
  logic [7:0] fifo_out;
  logic       fifo_valid, fifo_in_ready, fifo_pop;
  logic       done, fifo_push;
  logic       slave, edge_sel, enabled, tick, half;
  logic       ctrl_hit, data_hit;
  logic [7:0] capt;
  logic [4:0] div_lim;
  logic       lead_edge, trail_edge;

  assign rst_n = s_r.rst_sync[1];
  sps_sync #(.WIDTH(3)) u_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sck_in, sdi, 1'b0}),
    .q     (pins_q)
  );
  // read buffer kept in a fifo; overflow flags an unread byte held in slave mode, not a full fifo
  sps_fifo #(.WIDTH(8), .DEPTH(`SPS_FIFO_DEPTH)) u_rbuf
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (capt),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign enabled  = s_r.ctrl[`SPS_CTRL_EN];
  assign slave    = (s_r.ctrl[2:0] >= `SPS_RATE_SLAVE);
  assign edge_sel = s_r.ctrl[`SPS_CTRL_EDGE];
  assign ctrl_hit = page_sel && cpu_addr == `SPS_ADDR_CTRL;
  assign data_hit = page_sel && cpu_addr == `SPS_ADDR_DATA;
  assign tick     = clk_src_slow ? slow_tick : instr_tick;
  assign div_lim  = 5'((6'd1 << s_r.ctrl[2:0]) - 6'd1);
  assign half     = tick && (s_r.div >= div_lim);
  // slave edges from synchronised pin; leading edge shifts out
  assign lead_edge  = (pins_q[2] != s_r.sck_prev) && (pins_q[2] == ~edge_sel);
  assign trail_edge = (pins_q[2] != s_r.sck_prev) && (pins_q[2] == edge_sel);
  // master samples two clocks late to make up for the pin synchroniser
  assign capt = slave ? {s_r.shift_register[6:0], pins_q[1]} : {s_r.rx_sr[6:0], pins_q[1]};
  // slave mode keeps a one-deep visible buffer: overflow when an unread byte is held; master pushes while the fifo has room
  assign fifo_push = done && (!slave || !fifo_valid) && fifo_in_ready;
  assign fifo_pop  = cpu_rd && data_hit && fifo_valid;

  always_comb
  begin
    s_nxt = s_r;
    done = 1'b0;
    s_nxt.rst_sync = {s_r.rst_sync[0], 1'b1};
    s_nxt.sck_prev = pins_q[2];
    s_nxt.cap = {s_r.cap[0], 1'b0};
    s_nxt.fin = {s_r.fin[0], 1'b0};
    if (cpu_wr && ctrl_hit)
    begin
      s_nxt.ctrl[6:0] = {cpu_wdata[6], s_r.ctrl[`SPS_CTRL_OVF] & cpu_wdata[5], cpu_wdata[4:0]};
      if (cpu_wdata[`SPS_CTRL_SE] && !s_r.busy && enabled)
      begin
        s_nxt.shift_register = s_r.write_buffer;
        s_nxt.busy = 1'b1;
        s_nxt.bitcnt = 3'h0;
        s_nxt.phase = SPS_LEAD;
      end
    end
    if (cpu_wr && data_hit && !s_r.busy && enabled)
    begin
      s_nxt.write_buffer = cpu_wdata;
      s_nxt.shift_register = cpu_wdata;
      s_nxt.busy = 1'b1;
      s_nxt.ctrl[`SPS_CTRL_SE] = 1'b1;
      s_nxt.bitcnt = 3'h0;
      s_nxt.phase = SPS_LEAD;
    end
    if (s_r.busy && !enabled)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.phase = SPS_IDLE;
    end
    else if (s_r.busy && !slave)
    begin
      s_nxt.div = tick ? (half ? 5'h0 : s_r.div + 5'h1) : s_r.div;
      if (s_r.cap[1])
      begin
        s_nxt.rx_sr = capt;
        if (s_r.fin[1])
          done = 1'b1;
      end
      if (half)
        case (s_r.phase)
          SPS_LEAD:
          begin
            s_nxt.sdo = s_r.shift_register[7];
            s_nxt.sck = ~edge_sel;
            s_nxt.phase = SPS_TRAIL;
          end
          SPS_TRAIL:
          begin
            s_nxt.sck = edge_sel;
            s_nxt.shift_register = {s_r.shift_register[6:0], 1'b0};
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
            s_nxt.cap[0] = 1'b1;
            s_nxt.fin[0] = (s_r.bitcnt == 3'h7);
            // after the eighth bit the clock stays idle until the late sample lands
            s_nxt.phase = (s_r.bitcnt == 3'h7) ? SPS_IDLE : SPS_LEAD;
          end
          default: s_nxt.phase = SPS_IDLE;
        endcase
    end
    else if (s_r.busy)
    begin
      if (lead_edge)
        s_nxt.sdo = s_r.shift_register[7];
      if (trail_edge)
      begin
        s_nxt.shift_register = capt;
        s_nxt.bitcnt = s_r.bitcnt + 3'h1;
        if (s_r.bitcnt == 3'h7)
          done = 1'b1;
      end
    end
    if (!s_r.busy || slave)
      s_nxt.sck = edge_sel;
    if (done)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.phase = SPS_IDLE;
      s_nxt.div = 5'h0;
      if (slave && fifo_valid && !fifo_pop)
        s_nxt.ctrl[`SPS_CTRL_OVF] = 1'b1;
      s_nxt.irq = 1'b1;
    end
    else if (irq_clear)
      s_nxt.irq = 1'b0;
    // shift enable stays until software clears it; held at one while busy
    if (s_nxt.busy)
      s_nxt.ctrl[`SPS_CTRL_SE] = 1'b1;
    s_nxt.ctrl[`SPS_CTRL_RBF] = 1'b0;
    if (ctrl_hit)
      s_nxt.rdata = {fifo_valid, s_r.ctrl[6:0]};
    else if (data_hit)
      s_nxt.rdata = fifo_out;
    else
      s_nxt.rdata = 8'h00;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.ctrl <= `SPS_CTRL_RESET;
      s_r.phase <= SPS_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign cpu_rdata            = s_r.rdata;
  assign read_buffer_full_irq = s_r.irq;
  assign sck_out              = s_r.sck;
  assign sck_oe               = enabled && !slave;
  assign sdo                  = s_r.sdo;
  assign sdo_oe               = enabled;
endmodule

// ### verilog/sps_regs.svh
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_ADDR_CTRL     8'h04
`define SPS_ADDR_DATA     8'h05
`define SPS_ADDR_STATUS   8'h03
`define SPS_STATUS_PAGE   7
`define SPS_CTRL_RBF      7
`define SPS_CTRL_EN       6
`define SPS_CTRL_OVF      5
`define SPS_CTRL_SE       4
`define SPS_CTRL_EDGE     3
`define SPS_CTRL_RESET    8'h00
`define SPS_RATE_SLAVE    3'h6
`define SPS_FIFO_DEPTH    16
`endif

// ### verilog/sps_pkg.sv
package sps_pkg;
  typedef enum {SPS_IDLE, SPS_LEAD, SPS_TRAIL} sps_phase_t;
endpackage

// ### verilog/sps_fifo.sv
`timescale 1ns/10ps
module sps_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } sps_fifo_st_t;
  sps_fifo_st_t s_r, s_nxt;
  logic push, pop;
  assign in_ready  = (s_r.cnt != DEPTH[AW:0]);
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = s_r.rp + 1'b1;
    case ({push, pop})
      2'b10: s_nxt.cnt = s_r.cnt + 1'b1;
      2'b01: s_nxt.cnt = s_r.cnt - 1'b1;
      default: s_nxt.cnt = s_r.cnt;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// ### verilog/sps_sync.sv
`timescale 1ns/10ps
module sps_sync
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sps_sync_st_t;
  sps_sync_st_t s_r, s_nxt;
  always_comb
  begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign q = s_r.s2;
endmodule

// ### tb/sps_port_assertions.sv
`timescale 1ns/10ps
module sps_port_checker
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic       page_sel,
  input wire logic       irq_clear,
  input wire logic       read_buffer_full_irq,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       sdo,
  input wire logic       sdo_oe
);
  logic       en_r, edge_r, mst_r, busy_r, irq_r, sck_r;
  logic [5:0] tg_r;
  logic       go;
  assign go = cpu_wr && page_sel && cpu_addr == 8'h05 && en_r && mst_r && !busy_r;
  // clock toggles since the last accepted byte; a restart by a blocked write shows up here
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      en_r   <= 1'b0;
      edge_r <= 1'b0;
      mst_r  <= 1'b0;
      busy_r <= 1'b0;
      irq_r  <= 1'b0;
      sck_r  <= 1'b0;
      tg_r   <= 6'h00;
    end
    else
    begin
      if (cpu_wr && page_sel && cpu_addr == 8'h04)
      begin
        en_r   <= cpu_wdata[6];
        edge_r <= cpu_wdata[3];
        mst_r  <= cpu_wdata[2:0] < 3'h6;
      end
      irq_r  <= read_buffer_full_irq;
      sck_r  <= sck_out;
      busy_r <= go || (busy_r && !(read_buffer_full_irq && !irq_r));
      tg_r   <= go ? 6'h00 : tg_r + 6'(sck_out != sck_r);
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_irq_hold;
    read_buffer_full_irq && !irq_clear |=> read_buffer_full_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_irq_src;
    $rose(read_buffer_full_irq) |-> busy_r;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without byte");
  property p_count;
    $rose(read_buffer_full_irq) |-> tg_r + 6'(sck_out != sck_r) == 6'h10;
  endproperty
  a_count: assert property (p_count) else $error("clock edge count");
  property p_idle;
    $rose(read_buffer_full_irq) |-> sck_out == edge_r;
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle level");
  property p_start;
    go |-> ##[1:100] sck_out != edge_r;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_drive;
    busy_r |-> sck_oe && sdo_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("pins not driven");
  property p_off;
    !en_r && !$past(en_r) |-> !sck_oe && !sdo_oe;
  endproperty
  a_off: assert property (p_off) else $error("driving while off");
  property p_hold;
    busy_r && (edge_r ? $rose(sck_out) : $fell(sck_out)) |-> $stable(sdo);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved at sample");
endmodule

// ### tb/sps_slave_model.sv
`timescale 1ns/10ps
module sps_slave_model
(
  input  wire logic       sck,
  input  wire logic       edge_hi,
  input  wire logic       sdo,
  input  wire logic       clr,
  input  wire logic [7:0] tx,
  output logic            sdi,
  output logic      [7:0] rx
);
  int n = 0;
  initial
    sdi = 1'b0;
  always @(posedge clr)
    n = 0;
  // lead edge drives, trail edge samples, msb first
  always @(sck)
    if (sck ^ edge_hi)
      sdi = tx[3'(7 - n)];
    else
    begin
      rx = {rx[6:0], sdo};
      n  = n + 1;
      // no pull on the line, so a released bit shows inverted
      if (n == 8)
        sdi = ~sdi;
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic       clk = 1'b0, resetn = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, page_sel = 1'b1, slow_tick = 1'b0;
  logic       clk_src_slow = 1'b0, irq_clear = 1'b0, edge_hi = 1'b0, clr = 1'b0;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, tx = 8'h00, cpu_rdata, rx, v;
  logic       read_buffer_full_irq, sck_out, sck_oe, sdi, sdo, sdo_oe;
  int         miscompares = 0, comparisons = 0, t0, k;
  sps_port uut (.clk, .resetn, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .page_sel,
    .instr_tick(1'b1), .slow_tick, .clk_src_slow, .irq_clear, .read_buffer_full_irq, .sck_in(1'b0),
    .sck_out, .sck_oe, .sdi, .sdo, .sdo_oe);
  sps_slave_model peer (.sck(sck_out), .edge_hi, .sdo, .clr, .tx, .sdi, .rx);
  always #5 clk = ~clk;
  always @(negedge clk)
    slow_tick <= ($time % 40) < 10;
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr  = a;
    cpu_wdata = d;
    cpu_wr    = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd   = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    v      = cpu_rdata;
  endtask
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task t_off;
    rd(8'h04);
    chk("ctrl reset", 8'h00, v);
    page_sel = 1'b0;
    wr(8'h04, 8'h40);
    page_sel = 1'b1;
    wr(8'h05, 8'h5a);
    repeat (40) @(negedge clk);
    rd(8'h04);
    chk("ctrl other page", 8'h00, v);
    chk("pins off", 8'h00, {5'h0, sck_oe, sdo_oe, read_buffer_full_irq});
    $display("disabled port test done");
  endtask
  task t_xfer(input logic [2:0] c, input logic e, input logic s, input logic [7:0] d);
    edge_hi      = e;
    clk_src_slow = s;
    tx           = ~d;
    wr(8'h04, {4'h4, e, c});
    @(negedge clk);
    chk("idle clock", {7'h0, e}, {7'h0, sck_out});
    clr = 1'b1;
    wr(8'h05, d);
    clr = 1'b0;
    @(sck_out);
    t0 = $time;
    @(sck_out);
    chk("half period", s ? 8'h04 : 8'h01 << c, 8'(($time - t0) / 10));
    if (c > 3'h2)
    begin
      rd(8'h04);
      chk("ctrl busy", {4'h5, e, c}, v);
      wr(8'h05, 8'hff);
    end
    for (k = 0; k < 5000 && read_buffer_full_irq !== 1'b1; k++)
      @(negedge clk);
    chk("peer byte", d, rx);
    rd(8'h04);
    chk("ctrl done", {4'hd, e, c}, v);
    rd(8'h05);
    chk("read buffer", ~d, v);
    rd(8'h04);
    chk("ctrl read", {4'h5, e, c}, v);
    chk("irq held", 8'h01, {7'h0, read_buffer_full_irq});
    irq_clear = 1'b1;
    @(negedge clk);
    irq_clear = 1'b0;
    @(negedge clk);
    chk("irq cleared", 8'h00, {7'h0, read_buffer_full_irq});
    wr(8'h04, {4'h4, e, c});
    $display("transfer rate %0d edge %0d slow %0d done", c, e, s);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_off();
    for (int c = 0; c < 6; c++)
      t_xfer(3'(c), 1'b0, 1'b0, 8'ha5 ^ 8'(c));
    t_xfer(3'h3, 1'b1, 1'b0, 8'h3c);
    t_xfer(3'h0, 1'b0, 1'b1, 8'hc3);
    wrap_up();
  end
  // the full run is near 1400 cycles, so this leaves a wide margin
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
bind sps_port sps_port_checker u_chk (.clk, .resetn, .cpu_addr, .cpu_wr, .cpu_wdata, .page_sel, .irq_clear,
  .read_buffer_full_irq, .sck_out, .sck_oe, .sdo, .sdo_oe);
